// File: include/tmr2_consts.svh
`ifndef TMR2_CONSTS_SVH
`define TMR2_CONSTS_SVH

// Control register field positions
`define TMR2_HIGH_OVF_BIT   3'd7
`define TMR2_LOW_OVF_BIT    3'd6
`define TMR2_LOW_IRQ_EN_BIT 3'd5
`define TMR2_CAPT_EN_BIT    3'd4
`define TMR2_SPLIT_BIT      3'd3
`define TMR2_RUN_BIT        3'd2
`define TMR2_ALT_CLK_MSB    3'd1
`define TMR2_ALT_CLK_LSB    3'd0

// Reset values
`define TMR2_CTRL_RESET     8'h00
`define TMR2_COUNT_RESET    16'h0000
`define TMR2_RELOAD_RESET   16'h0000

// Timing counts
`define TMR2_SYS_DIV        4'd12
// Last phase of the slow divide-by-8, so the first tick needs eight rises
`define TMR2_SLOW_DIV       3'd7
`define TMR2_BYTE_MAX       8'hff

`endif

// File: include/tmr2_pkg.sv
package tmr2_pkg;

    typedef enum logic [1:0] {
        TMR2_ALT_SYSDIV12 = 2'b00,
        TMR2_ALT_COMP0    = 2'b01,
        TMR2_ALT_SYSDIV_B = 2'b10,
        TMR2_ALT_SLOWDIV8 = 2'b11
    } tmr2_alt_e;

    typedef struct packed {
        logic      high_overflow_flag;
        logic      low_overflow_flag;
        logic      low_byte_irq_enable;
        logic      capture_enable;
        logic      split_mode_enable;
        logic      run_control;
        tmr2_alt_e alt_clock_select;
    } tmr2_ctrl_s;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } tmr2_word_s;

endpackage : tmr2_pkg

// File: logic/tmr2_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser; stage one feeds only stage two
module tmr2_sync (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Data
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : tmr2_sync

// File: logic/tmr2_ctrl.sv
`timescale 1ns/1ps
// Function
// - High byte wrap sets high flag
// - 16-bit wrap sets high flag
// - High flag requests interrupt when enabled
// - High flag cleared only by software
// - Low byte wrap sets low flag always
// - Low enable plus irq enable interrupts low
// - Capture enable selects capture mode
// - Split bit gives two 8-bit timers
// - Run bit gates counting in 16-bit
// - Split: run gates only high byte
// - Split: per-byte system_clock or external select
// - External source decode by two-bit field
// - Capture trigger decode by high bit of same field
// - External sources synchronised before use
// - 16-bit overflow loads reload value
// - Capture copies count, sets high flag
`include "tmr2_consts.svh"
module tmr2_ctrl (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    // Control register port
    input  wire logic                 ctrl_wr_in,
    input  wire tmr2_pkg::tmr2_ctrl_s ctrl_wdata_in,
    output tmr2_pkg::tmr2_ctrl_s      ctrl_rdata_out,
    // Count and reload writes
    input  wire logic                 count_wr_in,
    input  wire tmr2_pkg::tmr2_word_s count_wdata_in,
    input  wire logic                 reload_wr_in,
    input  wire tmr2_pkg::tmr2_word_s reload_wdata_in,
    output tmr2_pkg::tmr2_word_s      count_out,
    output tmr2_pkg::tmr2_word_s      reload_out,
    // Clock select bits from clock control
    input  wire logic                 high_byte_system_clock_select_in,
    input  wire logic                 low_byte_system_clock_select_in,
    // Asynchronous sources
    input  wire logic                 comparator0_in,
    input  wire logic                 slow_osc_in,
    // Interrupt
    input  wire logic                 timer_irq_enable_in,
    output logic                      timer_irq_out
);
    import tmr2_pkg::*;

    // Comparator and slow oscillator live in other clock domains
    logic       comp_s;
    logic       slow_s;
    tmr2_sync u_sync_comp (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .async_in (comparator0_in),
        .sync_out (comp_s)
    );
    tmr2_sync u_sync_slow (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .async_in (slow_osc_in),
        .sync_out (slow_s)
    );

    tmr2_ctrl_s ctrl_q;
    tmr2_ctrl_s ctrl_d;
    tmr2_word_s cnt_q;
    tmr2_word_s cnt_d;
    tmr2_word_s rld_q;
    tmr2_word_s rld_d;
    logic       comp_prev_q;
    logic       comp_prev_d;
    logic       slow_prev_q;
    logic       slow_prev_d;
    logic [3:0] div12_q;
    logic [3:0] div12_d;
    logic [2:0] div8_q;
    logic [2:0] div8_d;

    logic comp_rise;
    logic slow_rise;
    logic sys12_tick;
    logic slow8_tick;
    logic ext_tick;
    logic capt_tick;
    logic tick_h;
    logic tick_l;
    logic low_wrap;
    logic high_wrap;
    logic full_wrap;
    logic capt_event;
    logic set_high;
    logic set_low;
    logic irq_high;
    logic irq_low;

    // Edge detectors and prescalers
    always_comb begin
        comp_rise   = comp_s & ~comp_prev_q;
        slow_rise   = slow_s & ~slow_prev_q;
        comp_prev_d = comp_s;
        slow_prev_d = slow_s;
        sys12_tick  = (div12_q == `TMR2_SYS_DIV - 4'd1);
        div12_d     = sys12_tick ? 4'd0 : div12_q + 4'd1;
        // Tick on the eighth rise, not on the first after reset
        slow8_tick  = slow_rise && (div8_q == `TMR2_SLOW_DIV);
        div8_d      = slow_rise ? div8_q + 3'd1 : div8_q;
    end

    // External source and capture trigger selection
    always_comb begin
        case (ctrl_q.alt_clock_select)
            TMR2_ALT_SYSDIV12: ext_tick = sys12_tick;
            TMR2_ALT_COMP0:    ext_tick = comp_rise;
            TMR2_ALT_SYSDIV_B: ext_tick = sys12_tick;
            TMR2_ALT_SLOWDIV8: ext_tick = slow8_tick;
            default:           ext_tick = 1'b0;
        endcase
        capt_tick  = ctrl_q.alt_clock_select[1] ? comp_rise : slow8_tick;
        capt_event = ctrl_q.capture_enable && capt_tick;
        tick_h     = high_byte_system_clock_select_in ? 1'b1 : ext_tick;
        tick_l     = low_byte_system_clock_select_in ? 1'b1 : ext_tick;
    end

    // Counter next state
    always_comb begin
        cnt_d     = cnt_q;
        low_wrap  = 1'b0;
        high_wrap = 1'b0;
        full_wrap = 1'b0;
        if (ctrl_q.split_mode_enable) begin
            // Low byte ignores the run bit in split mode
            if (tick_l) begin
                low_wrap  = (cnt_q.low == `TMR2_BYTE_MAX);
                cnt_d.low = low_wrap ? rld_q.low : cnt_q.low + 8'h01;
            end
            if (tick_h && ctrl_q.run_control) begin
                high_wrap  = (cnt_q.high == `TMR2_BYTE_MAX);
                cnt_d.high = high_wrap ? rld_q.high : cnt_q.high + 8'h01;
            end
        end else if (ctrl_q.run_control && tick_l) begin
            // Low byte carry moves the high byte
            low_wrap  = (cnt_q.low == `TMR2_BYTE_MAX);
            full_wrap = low_wrap && (cnt_q.high == `TMR2_BYTE_MAX);
            high_wrap = full_wrap;
            cnt_d     = full_wrap ? rld_q : tmr2_word_s'(cnt_q + 16'h0001);
        end
        // A count write overrides counting in that cycle
        if (count_wr_in) begin
            cnt_d = count_wdata_in;
        end
    end

    // Reload word; capture overrides the reload write in the same cycle
    always_comb begin
        rld_d = rld_q;
        if (reload_wr_in) begin
            rld_d = reload_wdata_in;
        end
        if (capt_event) begin
            rld_d = cnt_q;
        end
    end

    // Flags: a hardware set beats a clearing write in the same cycle
    always_comb begin
        set_high = high_wrap || capt_event;
        set_low  = low_wrap;
        ctrl_d   = ctrl_q;
        if (ctrl_wr_in) begin
            ctrl_d = ctrl_wdata_in;
        end
        if (set_high) begin
            ctrl_d.high_overflow_flag = 1'b1;
        end
        if (set_low) begin
            ctrl_d.low_overflow_flag = 1'b1;
        end
    end

    // Source state registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            comp_prev_q <= 1'b0;
            slow_prev_q <= 1'b0;
            div12_q     <= 4'd0;
            div8_q      <= 3'd0;
        end else begin
            comp_prev_q <= comp_prev_d;
            slow_prev_q <= slow_prev_d;
            div12_q     <= div12_d;
            div8_q      <= div8_d;
        end
    end

    // Count word register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= tmr2_word_s'(`TMR2_COUNT_RESET);
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Reload word register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rld_q <= tmr2_word_s'(`TMR2_RELOAD_RESET);
        end else begin
            rld_q <= rld_d;
        end
    end

    // Control register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_q <= tmr2_ctrl_s'(`TMR2_CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Level request while any enabled flag stands
    assign irq_high      = ctrl_q.high_overflow_flag;
    assign irq_low       = ctrl_q.low_byte_irq_enable && ctrl_q.low_overflow_flag;
    assign timer_irq_out = timer_irq_enable_in && (irq_high || irq_low);
    assign ctrl_rdata_out = ctrl_q;
    assign count_out      = cnt_q;
    assign reload_out     = rld_q;
endmodule : tmr2_ctrl

// File: test/tmr2_ctrl_monitor.sv
`timescale 1ns/1ps
module tmr2_ctrl_monitor
    import tmr2_pkg::*;
(
    // Clock and reset
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    // Watched ports
    input wire logic       ctrl_wr_in,
    input wire tmr2_ctrl_s ctrl_wdata_in,
    input wire tmr2_ctrl_s ctrl_rdata_out,
    input wire logic       count_wr_in,
    input wire tmr2_word_s count_wdata_in,
    input wire logic       reload_wr_in,
    input wire tmr2_word_s reload_wdata_in,
    input wire tmr2_word_s count_out,
    input wire tmr2_word_s reload_out,
    input wire logic       high_byte_system_clock_select_in,
    input wire logic       low_byte_system_clock_select_in,
    input wire logic       comparator0_in,
    input wire logic       slow_osc_in,
    input wire logic       timer_irq_enable_in,
    input wire logic       timer_irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic sp = ctrl_rdata_out.split_mode_enable;
    wire logic rn = ctrl_rdata_out.run_control;
    wire logic hf = ctrl_rdata_out.high_overflow_flag;
    wire logic lf = ctrl_rdata_out.low_overflow_flag;
    wire logic hs = high_byte_system_clock_select_in;
    wire logic ls = low_byte_system_clock_select_in;
    sequence s_wrap16;
        !sp && rn && hs && ls && !count_wr_in && !reload_wr_in && count_out == 16'hffff;
    endsequence
    sequence s_reloaded;
        count_out == $past(reload_out) && hf && lf;
    endsequence
    a_wrap_reload:
        assert property (s_wrap16 |=> s_reloaded) else $error("16-bit wrap wrong");
    a_irq_high:
        assert property (hf && timer_irq_enable_in |-> timer_irq_out) else $error("irq missing");
    a_irq_low:
        assert property (lf && ctrl_rdata_out.low_byte_irq_enable && timer_irq_enable_in
            |-> timer_irq_out) else $error("low irq missing");
    a_irq_gated:
        assert property (!timer_irq_enable_in |-> !timer_irq_out) else $error("irq not gated");
    a_high_sticky:
        assert property (hf && !ctrl_wr_in |=> hf) else $error("high flag self-cleared");
    a_low_sticky:
        assert property (lf && !ctrl_wr_in |=> lf) else $error("low flag self-cleared");
    a_run_gate:
        assert property (!sp && !rn && !count_wr_in |=> $stable(count_out))
        else $error("count moved while stopped");
    a_split_low:
        assert property (sp && ls && !count_wr_in && count_out.low != 8'hff
            |=> count_out.low == $past(count_out.low) + 8'h01) else $error("low byte stalled");
    a_split_high:
        assert property (sp && rn && hs && !count_wr_in && !reload_wr_in && count_out.high == 8'hff
            |=> hf && count_out.high == $past(reload_out.high)) else $error("high wrap wrong");
    a_reload_hold:
        assert property (!ctrl_rdata_out.capture_enable && !reload_wr_in |=> $stable(reload_out))
        else $error("reload moved without capture");
    a_low_wrap16:
        assert property (!sp && rn && ls && !count_wr_in && count_out.low == 8'hff |=> lf)
        else $error("low flag not set on 16-bit wrap");
endmodule : tmr2_ctrl_monitor

bind tmr2_ctrl tmr2_ctrl_monitor mon_u (.clk_in, .rst_n_in, .ctrl_wr_in, .ctrl_wdata_in,
    .ctrl_rdata_out, .count_wr_in, .count_wdata_in, .reload_wr_in, .reload_wdata_in,
    .count_out, .reload_out, .high_byte_system_clock_select_in, .low_byte_system_clock_select_in,
    .comparator0_in, .slow_osc_in, .timer_irq_enable_in, .timer_irq_out);

// File: test/test_tmr2_ctrl.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
    checks++; \
    if ((gt) !== (ex)) begin \
        miscompares++; \
        $display("[FAIL] %s exp %h got %h", nm, ex, gt); \
    end
module test_tmr2_ctrl;
    import tmr2_pkg::*;
    logic clk_in = 1'b0, rst_n_in = 1'b0, cw = 1'b0, nw = 1'b0, rw = 1'b0, irq;
    logic hs = 1'b1, ls = 1'b1, cmp = 1'b0, ien = 1'b1, slw = 1'b0;
    tmr2_ctrl_s cd = 8'h00, cr;
    tmr2_word_s nd = 16'h0000, rd = 16'h0000, cnt, rl;
    int checks = 0, miscompares = 0;
    always #5 clk_in = ~clk_in;
    tmr2_ctrl dut_u (.clk_in, .rst_n_in, .ctrl_wr_in(cw), .ctrl_wdata_in(cd),
        .ctrl_rdata_out(cr), .count_wr_in(nw), .count_wdata_in(nd), .reload_wr_in(rw),
        .reload_wdata_in(rd), .count_out(cnt), .reload_out(rl),
        .high_byte_system_clock_select_in(hs), .low_byte_system_clock_select_in(ls),
        .comparator0_in(cmp), .slow_osc_in(slw), .timer_irq_enable_in(ien),
        .timer_irq_out(irq));
    task automatic cyc(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc
    task automatic wctl(logic [7:0] v);
        cd = v;
        cw = 1'b1;
        cyc(1);
        cw = 1'b0;
    endtask : wctl
    task automatic wcnt(logic [15:0] v);
        nd = v;
        nw = 1'b1;
        cyc(1);
        nw = 1'b0;
    endtask : wcnt
    task automatic wrl(logic [15:0] v);
        rd = v;
        rw = 1'b1;
        cyc(1);
        rw = 1'b0;
    endtask : wrl
    task automatic t_wrap;
        wrl(16'h1234);
        wcnt(16'hfffe);
        wctl(8'h04);
        cyc(1);
        // Clear lands on the wrap edge; the set must survive
        wctl(8'h04);
        `CHK("count", 16'h1234, cnt);
        `CHK("ctrl", 8'hc4, cr);
        `CHK("irq", 1'b1, irq);
        ien = 1'b0;
        cyc(1);
        `CHK("irq gated", 1'b0, irq);
        ien = 1'b1;
        wctl(8'h00);
        `CHK("cleared", 8'h00, cr);
        `CHK("irq off", 1'b0, irq);
        wcnt(16'h00ff);
        cyc(3);
        `CHK("stopped", 16'h00ff, cnt);
    endtask : t_wrap
    task automatic t_split;
        wrl(16'h5577);
        wcnt(16'h10fe);
        wctl(8'h28);
        cyc(2);
        `CHK("split low", 16'h1077, cnt);
        `CHK("low flag", 8'h68, cr);
        `CHK("low irq", 1'b1, irq);
        wcnt(16'hff00);
        wctl(8'h2c);
        cyc(1);
        `CHK("split high", 16'h5502, cnt);
        `CHK("high flag", 8'hac, cr);
        wctl(8'h00);
    endtask : t_split
    task automatic t_ext;
        hs = 1'b0;
        ls = 1'b0;
        wcnt(16'h0000);
        wctl(8'h05);
        repeat (3) begin
            cmp = 1'b1;
            cyc(4);
            cmp = 1'b0;
            cyc(4);
        end
        `CHK("cmp clock", 16'h0003, cnt);
        hs = 1'b1;
        ls = 1'b1;
        wctl(8'h12);
        wcnt(16'h4321);
        cmp = 1'b1;
        cyc(2);
        `CHK("sync delay", 1'b0, cr.high_overflow_flag);
        cyc(1);
        `CHK("capt edge", 1'b1, cr.high_overflow_flag);
        cyc(2);
        `CHK("capture", 16'h4321, rl);
        `CHK("capt flag", 8'h92, cr);
        cmp = 1'b0;
    endtask : t_ext
    task automatic pulse;
        slw = 1'b1;
        cyc(2);
        slw = 1'b0;
        cyc(2);
    endtask : pulse
    task automatic t_slow;
        hs = 1'b0;
        ls = 1'b0;
        wctl(8'h00);
        wcnt(16'h0000);
        wctl(8'h04);
        cyc(24);
        `CHK("div12 code0", 16'h0002, cnt);
        wctl(8'h02);
        wcnt(16'h0000);
        wctl(8'h06);
        cyc(24);
        `CHK("div12 code2", 16'h0002, cnt);
        wctl(8'h03);
        wcnt(16'h0000);
        wctl(8'h07);
        repeat (7) pulse();
        `CHK("div8 early", 16'h0000, cnt);
        pulse();
        `CHK("div8 tick", 16'h0001, cnt);
        wctl(8'h10);
        wcnt(16'h0abc);
        repeat (8) pulse();
        `CHK("slow capture", 16'h0abc, rl);
        `CHK("slow flag", 8'h90, cr);
        rst_n_in = 1'b0;
        cyc(2);
        rst_n_in = 1'b1;
        `CHK("mid reset reload", 16'h0000, rl);
        `CHK("mid reset ctrl", 8'h00, cr);
        `CHK("mid reset irq", 1'b0, irq);
    endtask : t_slow
    task automatic summarize;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        #20000;
        miscompares++;
        summarize();
    end
    initial begin
        cyc(4);
        rst_n_in = 1'b1;
        `CHK("reset", 8'h00, cr);
        t_wrap();
        t_split();
        t_ext();
        t_slow();
        summarize();
    end
endmodule : test_tmr2_ctrl
